/* src/buck_regs_pkg.sv */
// Purpose: constants for the step-down channel register bank
// Assumes: 40 MHz system clock, byte-wide register port
// Notes:   offsets are byte addresses on the register port
package buck_regs_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_CH3_STATUS   = 8'h80;
    localparam logic [7:0] ADDR_CH3_MASK     = 8'h81;
    localparam logic [7:0] ADDR_CH3_VACT     = 8'h85;
    localparam logic [7:0] ADDR_CH3_VALT     = 8'h86;
    localparam logic [7:0] ADDR_CH3_ENSLP    = 8'h87;
    localparam logic [7:0] ADDR_CH3_SEQRST   = 8'h88;
    localparam logic [7:0] ADDR_CH3_DELAY    = 8'h89;
    localparam logic [7:0] ADDR_CH3_LIMFLT   = 8'h8A;
    localparam logic [7:0] ADDR_CH3_THRSLEW  = 8'h8B;
    localparam logic [7:0] ADDR_CH3_FREQDIS  = 8'h8C;
    localparam logic [7:0] ADDR_CH4_STATUS   = 8'hA0;
    localparam logic [7:0] ADDR_CH4_MASK     = 8'hA1;

    // Values after reset
    localparam logic [7:0] RST_MASK    = 8'hDC;
    localparam logic [7:0] RST_VACT    = 8'h5F;
    localparam logic [7:0] RST_VALT    = 8'h5F;
    localparam logic [7:0] RST_ENSLP   = 8'h0F;
    localparam logic [7:0] RST_SEQRST  = 8'h13;
    localparam logic [7:0] RST_DELAY   = 8'hC2;
    localparam logic [7:0] RST_LIMFLT  = 8'h40;
    localparam logic [7:0] RST_THRSLEW = 8'hDC;
    localparam logic [7:0] RST_FREQDIS = 8'h06;

    // Status and mask bit positions (shared layout)
    localparam int BIT_PG    = 7;
    localparam int BIT_OV    = 6;
    localparam int BIT_SHUT  = 4;
    localparam int BIT_FAULT = 3;
    localparam int BIT_WARN  = 2;
    // Event vector index: {pg, ov, shut, fault, warn}
    localparam int EV_PG    = 4;
    localparam int EV_OV    = 3;
    localparam int EV_SHUT  = 2;
    localparam int EV_FAULT = 1;
    localparam int EV_WARN  = 0;

    // Control field positions
    localparam int BIT_DIRECT_EN   = 3;
    localparam int BIT_HOLD        = 2;
    localparam int BIT_SLEEP_OFF   = 1;
    localparam int BIT_DSLEEP_OFF  = 0;
    localparam int BIT_RESET_LINK  = 6;
    localparam int POS_ON_DLY      = 4;
    localparam int BIT_IN_REG_OFF  = 5;
    localparam int BIT_IN_SYS_OFF  = 4;
    localparam int BIT_OUT_REG_OFF = 3;
    localparam int BIT_OUT_SYS_OFF = 2;
    localparam int BIT_DIS_DISABLE = 7;
    localparam int BIT_DIS_RES     = 6;
    localparam int BIT_STEP_SEL    = 4;

    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int QTR_MS_NS     = 250000;
    localparam int QTR_MS_CYC    = (QTR_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] QTRS_PER_MS = 8'h04;

    typedef enum logic [1:0] {
        ST_OFF      = 2'b00,
        ST_ON_WAIT  = 2'b01,
        ST_ON       = 2'b10,
        ST_OFF_WAIT = 2'b11
    } seq_state_e;

endpackage

/* src/buck_channel_regs.sv */
// Purpose: register bank and on/off control for step-down channel 3, plus status and mask for channel 4
// Assumes: byte register port from the serial front end, one clock
// Notes:   status bits other than power-good are read-to-clear, reserved status bits read zero
`timescale 1ns/1ps
module buck_channel_regs
    import buck_regs_pkg::*;
#(
    parameter int QTR_CYC = QTR_MS_CYC
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    // Register port
    input  wire logic [7:0]       reg_addr,
    input  wire logic             reg_wr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    // Comparator levels, [0]=ch3 [1]=ch4, {pg,ov,shut,fault,warn}
    input  wire logic [1:0][4:0]  cond_raw,
    // Channel 3 mode and sequencing pins
    input  wire logic             seq_in_raw,
    input  wire logic             sleep_raw,
    input  wire logic             deep_sleep_raw,
    input  wire logic             dvs_raw,
    input  wire logic             in_fault_raw,
    input  wire logic             out_fault_raw,
    // Events to the interrupt aggregator
    output logic      [1:0][4:0]  irq_evt,
    // Channel 3 power stage controls
    output logic                  ch3_enable,
    output logic      [7:0]       ch3_vcode,
    output logic                  step_size_sel,
    output logic      [3:0]       switch_sel_a,
    output logic                  discharge_en,
    output logic                  discharge_res_sel,
    output logic                  sys_off_req,
    output logic                  system_reset_n
);

////////////////////////////////////////////////////////////////////////
// Input synchronisers

    logic [1:0][4:0] cond_m_ff;
    logic [1:0][4:0] cond_s_ff;
    logic [5:0]      pin_m_ff;
    logic [5:0]      pin_s_ff;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cond_m_ff <= '0;
            cond_s_ff <= '0;
            pin_m_ff  <= '0;
            pin_s_ff  <= '0;
        end else begin
            cond_m_ff <= cond_raw;
            cond_s_ff <= cond_m_ff;
            pin_m_ff  <= {seq_in_raw, sleep_raw, deep_sleep_raw,
                          dvs_raw, in_fault_raw, out_fault_raw};
            pin_s_ff  <= pin_m_ff;
        end
    end

    logic seq_s;
    logic sleep_s;
    logic dsleep_s;
    logic dvs_s;
    logic in_flt_s;
    logic out_flt_s;
    assign {seq_s, sleep_s, dsleep_s, dvs_s, in_flt_s, out_flt_s} = pin_s_ff;

////////////////////////////////////////////////////////////////////////
// Configuration registers

    logic [1:0][7:0] mask_ff;
    logic [7:0]      vact_ff;
    logic [7:0]      valt_ff;
    logic [7:0]      enslp_ff;
    logic [7:0]      seqrst_ff;
    logic [7:0]      delay_ff;
    logic [7:0]      limflt_ff;
    logic [7:0]      thrslew_ff;
    logic [7:0]      freqdis_ff;

    // Reserved bits stored as written; host keeps them intact
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mask_ff    <= {RST_MASK, RST_MASK};
            vact_ff    <= RST_VACT;
            valt_ff    <= RST_VALT;
            enslp_ff   <= RST_ENSLP;
            seqrst_ff  <= RST_SEQRST;
            delay_ff   <= RST_DELAY;
            limflt_ff  <= RST_LIMFLT;
            thrslew_ff <= RST_THRSLEW;
            freqdis_ff <= RST_FREQDIS;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_CH3_MASK) begin
                mask_ff[0] <= reg_wdata;
            end else if (reg_addr == ADDR_CH4_MASK) begin
                mask_ff[1] <= reg_wdata;
            end else if (reg_addr == ADDR_CH3_VACT) begin
                vact_ff <= reg_wdata;
            end else if (reg_addr == ADDR_CH3_VALT) begin
                valt_ff <= reg_wdata;
            end else if (reg_addr == ADDR_CH3_ENSLP) begin
                enslp_ff <= reg_wdata;
            end else if (reg_addr == ADDR_CH3_SEQRST) begin
                seqrst_ff <= reg_wdata;
            end else if (reg_addr == ADDR_CH3_DELAY) begin
                delay_ff <= reg_wdata;
            end else if (reg_addr == ADDR_CH3_LIMFLT) begin
                limflt_ff <= reg_wdata;
            end else if (reg_addr == ADDR_CH3_THRSLEW) begin
                thrslew_ff <= reg_wdata;
            end else if (reg_addr == ADDR_CH3_FREQDIS) begin
                freqdis_ff <= reg_wdata;
            end
        end
    end

////////////////////////////////////////////////////////////////////////
// Fault flags and masked events, per channel

    logic [1:0][4:0] flag_ff;
    logic [1:0]      rd_clr;
    logic [1:0][7:0] status;

    assign rd_clr[0] = reg_rd && (reg_addr == ADDR_CH3_STATUS);
    assign rd_clr[1] = reg_rd && (reg_addr == ADDR_CH4_STATUS);

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            logic [4:0] mvec;
            assign mvec = {mask_ff[g][BIT_PG], mask_ff[g][BIT_OV],
                           mask_ff[g][BIT_SHUT], mask_ff[g][BIT_FAULT],
                           mask_ff[g][BIT_WARN]};

            // Set wins; OV, shut, fault, warn clear only on a read after the level dropped; PG follows its level
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    flag_ff[g] <= '0;
                end else begin
                    flag_ff[g][EV_PG]    <= cond_s_ff[g][EV_PG];
                    flag_ff[g][EV_OV]    <= cond_s_ff[g][EV_OV] |
                        (flag_ff[g][EV_OV] & ~rd_clr[g]);
                    flag_ff[g][EV_SHUT]  <= cond_s_ff[g][EV_SHUT] |
                        (flag_ff[g][EV_SHUT] & ~rd_clr[g]);
                    flag_ff[g][EV_FAULT] <= cond_s_ff[g][EV_FAULT] |
                        (flag_ff[g][EV_FAULT] & ~rd_clr[g]);
                    flag_ff[g][EV_WARN]  <= cond_s_ff[g][EV_WARN] |
                        (flag_ff[g][EV_WARN] & ~rd_clr[g]);
                end
            end

            // Power-good event is loss of regulation
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    irq_evt[g] <= '0;
                end else begin
                    irq_evt[g][EV_PG] <= ~cond_s_ff[g][EV_PG] & ~mvec[EV_PG];
                    irq_evt[g][EV_OV] <= flag_ff[g][EV_OV] & ~mvec[EV_OV];
                    irq_evt[g][EV_SHUT] <= flag_ff[g][EV_SHUT] & ~mvec[EV_SHUT];
                    irq_evt[g][EV_FAULT] <= flag_ff[g][EV_FAULT] & ~mvec[EV_FAULT];
                    irq_evt[g][EV_WARN] <= flag_ff[g][EV_WARN] & ~mvec[EV_WARN];
                end
            end

            assign status[g] = {flag_ff[g][EV_PG], flag_ff[g][EV_OV], 1'b0,
                                flag_ff[g][EV_SHUT], flag_ff[g][EV_FAULT],
                                flag_ff[g][EV_WARN], 2'b00};
        end
    endgenerate

////////////////////////////////////////////////////////////////////////
// Read data

    logic [7:0] nxt_rdata;

    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_addr == ADDR_CH3_STATUS) begin
            nxt_rdata = status[0];
        end else if (reg_addr == ADDR_CH4_STATUS) begin
            nxt_rdata = status[1];
        end else if (reg_addr == ADDR_CH3_MASK) begin
            nxt_rdata = mask_ff[0];
        end else if (reg_addr == ADDR_CH4_MASK) begin
            nxt_rdata = mask_ff[1];
        end else if (reg_addr == ADDR_CH3_VACT) begin
            nxt_rdata = vact_ff;
        end else if (reg_addr == ADDR_CH3_VALT) begin
            nxt_rdata = valt_ff;
        end else if (reg_addr == ADDR_CH3_ENSLP) begin
            nxt_rdata = enslp_ff;
        end else if (reg_addr == ADDR_CH3_SEQRST) begin
            nxt_rdata = seqrst_ff;
        end else if (reg_addr == ADDR_CH3_DELAY) begin
            nxt_rdata = delay_ff;
        end else if (reg_addr == ADDR_CH3_LIMFLT) begin
            nxt_rdata = limflt_ff;
        end else if (reg_addr == ADDR_CH3_THRSLEW) begin
            nxt_rdata = thrslew_ff;
        end else if (reg_addr == ADDR_CH3_FREQDIS) begin
            nxt_rdata = freqdis_ff;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= nxt_rdata;
        end
    end

////////////////////////////////////////////////////////////////////////
// On/off sequencer, counts in quarter milliseconds

    seq_state_e state_ff;
    logic [31:0] pre_ff;
    logic [7:0]  qtr_ff;
    logic        qtr_tick;
    logic [7:0]  on_qtrs;
    logic [7:0]  off_qtrs;
    logic [2:0]  on_code;
    logic        direct_en;
    logic        hold;
    logic        force_off;

    assign qtr_tick  = (pre_ff == 32'(QTR_CYC - 1));
    assign on_code   = delay_ff[POS_ON_DLY +: 3];
    // Codes step 0, 0.25, 0.5 ... 16 ms by doubling
    assign on_qtrs   = (on_code == 3'h0) ? 8'h00
                     : 8'(8'h01 << (on_code - 3'h1));
    assign off_qtrs  = 8'(delay_ff[3:0] * QTRS_PER_MS);
    assign direct_en = enslp_ff[BIT_DIRECT_EN];
    assign hold      = enslp_ff[BIT_HOLD];
    assign force_off = (sleep_s & enslp_ff[BIT_SLEEP_OFF])
                     | (dsleep_s & enslp_ff[BIT_DSLEEP_OFF])
                     | (in_flt_s & ~limflt_ff[BIT_IN_REG_OFF])
                     | (out_flt_s & ~limflt_ff[BIT_OUT_REG_OFF]);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_OFF;
            pre_ff   <= '0;
            qtr_ff   <= '0;
        end else begin
            pre_ff <= qtr_tick ? 32'h0 : pre_ff + 32'h1;
            if (qtr_tick && qtr_ff != 8'h00) begin
                qtr_ff <= qtr_ff - 8'h01;
            end
            case (state_ff)
                ST_OFF: begin
                    if (force_off) begin
                        state_ff <= ST_OFF;
                    end else if (direct_en) begin
                        state_ff <= ST_ON;
                    end else if (seq_s) begin
                        state_ff <= ST_ON_WAIT;
                        qtr_ff   <= on_qtrs;
                        pre_ff   <= '0;
                    end
                end
                ST_ON_WAIT: begin
                    if (force_off || !(seq_s || direct_en)) begin
                        state_ff <= ST_OFF;
                    end else if (direct_en || qtr_ff == 8'h00) begin
                        state_ff <= ST_ON;
                    end
                end
                ST_ON: begin
                    if (force_off) begin
                        state_ff <= ST_OFF;
                    end else if (!direct_en && !seq_s && !hold) begin
                        state_ff <= ST_OFF_WAIT;
                        qtr_ff   <= off_qtrs;
                        pre_ff   <= '0;
                    end
                end
                default: begin
                    if (force_off || qtr_ff == 8'h00) begin
                        state_ff <= ST_OFF;
                    end else if (direct_en || seq_s || hold) begin
                        state_ff <= ST_ON;
                    end
                end
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////
// Power stage outputs

    logic ch_off;
    assign ch_off = (state_ff == ST_OFF) || (state_ff == ST_ON_WAIT);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ch3_enable        <= 1'b0;
            ch3_vcode         <= RST_VACT;
            step_size_sel     <= 1'b0;
            switch_sel_a      <= 4'h0;
            discharge_en      <= 1'b0;
            discharge_res_sel <= 1'b0;
            sys_off_req       <= 1'b0;
            system_reset_n    <= 1'b1;
        end else begin
            ch3_enable        <= ~ch_off;
            // Alternate target in Sleep and scaling
            ch3_vcode         <= (sleep_s | dvs_s) ? valt_ff : vact_ff;
            step_size_sel     <= freqdis_ff[BIT_STEP_SEL];
            switch_sel_a      <= freqdis_ff[3:0];
            discharge_en      <= ch_off & ~freqdis_ff[BIT_DIS_DISABLE];
            discharge_res_sel <= freqdis_ff[BIT_DIS_RES];
            sys_off_req       <= (in_flt_s & ~limflt_ff[BIT_IN_SYS_OFF])
                               | (out_flt_s & ~limflt_ff[BIT_OUT_SYS_OFF]);
            system_reset_n    <= ~(ch_off & seqrst_ff[BIT_RESET_LINK]);
        end
    end

////////////////////////////////////////////////////////////////////////
// Assertions

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    AST_PG_MASK: assert property (
        mask_ff[0][BIT_PG] && $past(mask_ff[0][BIT_PG]) |-> !irq_evt[0][EV_PG])
        else $error("power-good event passed while masked");
    AST_OV_MASK: assert property (
        $past(mask_ff[1][BIT_OV]) |-> !irq_evt[1][EV_OV])
        else $error("overvoltage event passed while masked");
    AST_SHUT_MASK: assert property (
        $past(mask_ff[0][BIT_SHUT]) |-> !irq_evt[0][EV_SHUT])
        else $error("shutdown event passed while masked");
    AST_FAULT_UNMASKED: assert property (
        !mask_ff[0][BIT_FAULT] && flag_ff[0][EV_FAULT] |=> irq_evt[0][EV_FAULT])
        else $error("fault event lost while unmasked");
    AST_WARN_MASK: assert property (
        $past(mask_ff[0][BIT_WARN]) |-> !irq_evt[0][EV_WARN])
        else $error("warning event passed while masked");
    AST_PG_LIVE: assert property (
        cond_s_ff[0][EV_PG] ##1 !cond_s_ff[0][EV_PG] |-> ##1 !flag_ff[0][EV_PG])
        else $error("power-good status latched");
    AST_OV_STICKY: assert property (
        flag_ff[0][EV_OV] && !rd_clr[0] |=> flag_ff[0][EV_OV])
        else $error("overvoltage flag cleared without read");
    AST_SHUT_CLEAR: assert property (
        flag_ff[1][EV_SHUT] && rd_clr[1] && !cond_s_ff[1][EV_SHUT] |=> !flag_ff[1][EV_SHUT])
        else $error("shutdown flag not cleared by read");
    AST_FAULT_SET: assert property (
        cond_s_ff[0][EV_FAULT] |=> flag_ff[0][EV_FAULT] [*1] ##0 status[0][BIT_FAULT])
        else $error("fault flag not set");
    AST_WARN_HELD: assert property (
        cond_s_ff[1][EV_WARN] && rd_clr[1] |=> flag_ff[1][EV_WARN])
        else $error("warning flag cleared while active");
    AST_DIRECT_ON: assert property (
        state_ff == ST_OFF && direct_en && !force_off |=> ##1 ch3_enable)
        else $error("direct enable did not turn channel on");
    AST_SLEEP_OFF: assert property (
        state_ff == ST_ON && sleep_s && enslp_ff[BIT_SLEEP_OFF] |=> state_ff == ST_OFF)
        else $error("channel stayed on in sleep");
    AST_RESET_LINK: assert property (
        ch_off && seqrst_ff[BIT_RESET_LINK] |=> !system_reset_n)
        else $error("system reset not asserted");
    AST_READ_CAPTURE: assert property (
        rd_clr[0] && flag_ff[0][EV_OV] |=> reg_rdata[BIT_OV])
        else $error("flag lost on read");

    COV_DIRECT: cover property (state_ff == ST_OFF ##1 state_ff == ST_ON);
    COV_SEQ_ON: cover property (state_ff == ST_ON_WAIT ##[1:300] state_ff == ST_ON);
    COV_RD_CLR: cover property (flag_ff[0][EV_OV] && rd_clr[0] ##1 !flag_ff[0][EV_OV]);

endmodule // buck_channel_regs

/* bench/host_model.sv */
// Purpose: host side of the byte register port
// Assumes: one strobe per access, idle cycle between accesses
// Notes:   read data taken after the edge that accepts the read
`timescale 1ns/1ps
module host_model
    import buck_regs_pkg::*;
(
    // Clock
    input  wire logic       clk_sys,
    // Register port
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end
    // Callers pass reserved bits at their current values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
endmodule // host_model

/* bench/buck_channel_regs_tb_top.sv */
// Purpose: self-checking bench for the channel register bank
// Assumes: quarter-ms tick shortened to 4 cycles
// Notes:   async inputs need 3 edges to reach ch3_vcode and sys_off_req, 4 to reach ch3_enable and irq_evt flags
`timescale 1ns/1ps
module buck_channel_regs_tb_top;
    import buck_regs_pkg::*;
    logic            clk_sys, resetn;
    logic [7:0]      reg_addr, reg_wdata, reg_rdata, rv;
    logic            reg_wr, reg_rd, seq_in, slp, dslp, dvs, in_flt, out_flt;
    logic [1:0][4:0] cond, irq_evt;
    logic            en, step, res, dis_en, sys_off, rst_n;
    logic [7:0]      vcode;
    logic [3:0]      sw_sel;
    int              err_count, checks_done, cyc;
    ////////////////////////////////////////
    host_model i_host_model (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    buck_channel_regs #(.QTR_CYC(4)) i_buck_channel_regs (.clk_sys(clk_sys), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cond_raw(cond), .seq_in_raw(seq_in), .sleep_raw(slp),
        .deep_sleep_raw(dslp), .dvs_raw(dvs), .in_fault_raw(in_flt), .out_fault_raw(out_flt),
        .irq_evt(irq_evt), .ch3_enable(en), .ch3_vcode(vcode), .step_size_sel(step),
        .switch_sel_a(sw_sel), .discharge_en(dis_en), .discharge_res_sel(res),
        .sys_off_req(sys_off), .system_reset_n(rst_n));
    ////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic final_report();
        $display("checks=%0d errors=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc >= 6000) begin
            err_count++;
            final_report();
        end
    end
    ////////////////////////////////////////
    task automatic t_reset_values();
        logic [7:0] ad[11] = '{8'h81, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'hA1, 8'h90};
        logic [7:0] ex[11] = '{8'hDC, 8'h5F, 8'h5F, 8'h0F, 8'h13, 8'hC2, 8'h40, 8'hDC, 8'h06, 8'hDC, 8'h00};
        for (int i = 0; i < 11; i++) begin
            i_host_model.rd(ad[i], rv);
            chk(rv, ex[i]);
        end
    endtask
    // OV, shut, fault, warn flags: event while unmasked, withheld when masked, held until read; PG follows its level
    task automatic t_flags(input int c);
        logic [7:0] sa, ma;
        int         sb[4] = '{6, 4, 3, 2};
        sa = c ? 8'hA0 : 8'h80;
        ma = c ? 8'hA1 : 8'h81;
        for (int i = 0; i < 4; i++) begin
            i_host_model.wr(ma, 8'h00);
            cond[c][3-i] <= 1'b1;
            w(5);
            chk(irq_evt[c], 8'h10 | (8'h01 << (3 - i)));
            i_host_model.wr(ma, 8'hDC);
            w(3);
            chk(irq_evt[c], 8'h00);
            // Read while the level is still high must not clear the flag
            i_host_model.rd(sa, rv);
            chk(rv, 8'h01 << sb[i]);
            cond[c][3-i] <= 1'b0;
            w(5);
            i_host_model.rd(sa, rv);
            chk(rv, 8'h01 << sb[i]);
            i_host_model.rd(sa, rv);
            chk(rv, 8'h00);
        end
        cond[c][4] <= 1'b1;
        w(5);
        i_host_model.rd(sa, rv);
        chk(rv, 8'h80);
        cond[c][4] <= 1'b0;
        w(5);
        i_host_model.rd(sa, rv);
        chk(rv, 8'h00);
    endtask
    task automatic t_sequence();
        chk(en, 1'b1);
        i_host_model.wr(8'h88, 8'h53);
        i_host_model.wr(8'h87, 8'h00);
        w(20);
        chk(en, 1'b1);
        w(20);
        chk({en, rst_n, dis_en}, 3'b001);
        seq_in <= 1'b1;
        w(20);
        chk(en, 1'b0);
        w(20);
        chk({en, rst_n}, 2'b11);
        i_host_model.wr(8'h87, 8'h04);
        seq_in <= 1'b0;
        w(45);
        chk(en, 1'b1);
        i_host_model.wr(8'h87, 8'h06);
        slp <= 1'b1;
        w(5);
        chk(en, 1'b0);
        slp <= 1'b0;
        i_host_model.wr(8'h87, 8'h09);
        w(5);
        chk(en, 1'b1);
        dslp <= 1'b1;
        w(5);
        chk(en, 1'b0);
        dslp <= 1'b0;
        i_host_model.wr(8'h86, 8'h33);
        dvs <= 1'b1;
        w(5);
        chk(vcode, 8'h33);
        dvs <= 1'b0;
        w(5);
        chk(vcode, 8'h5F);
        i_host_model.wr(8'h8C, 8'hDF);
        w(3);
        chk({res, step, sw_sel, dis_en}, 8'h7E);
        in_flt <= 1'b1;
        w(5);
        chk({en, sys_off}, 2'b01);
        in_flt <= 1'b0;
        w(3);
        out_flt <= 1'b1;
        w(5);
        chk({en, sys_off}, 2'b01);
        out_flt <= 1'b0;
        i_host_model.wr(8'h8A, 8'h7C);
        {in_flt, out_flt} <= 2'b11;
        w(5);
        chk({en, sys_off}, 2'b10);
        {in_flt, out_flt} <= 2'b00;
    endtask
    // Mid-run reset restores defaults, then direct enable turns on again
    task automatic t_mid_reset();
        resetn <= 1'b0;
        w(2);
        chk({en, rst_n, dis_en, sys_off, step, res}, 8'h10);
        chk(irq_evt[0], 8'h00);
        resetn <= 1'b1;
        w(2);
        chk({en, sw_sel, dis_en}, 8'h0D);
        w(1);
        chk({en, rst_n, dis_en}, 3'b110);
        i_host_model.rd(8'h8C, rv);
        chk(rv, 8'h06);
    endtask
    ////////////////////////////////////////
    initial begin
        {resetn, seq_in, slp, dslp, dvs, in_flt, out_flt} = '0;
        cond = '0;
        err_count = 0;
        checks_done = 0;
        cyc = 0;
        w(20);
        resetn <= 1'b1;
        w(4);
        t_reset_values();
        t_flags(0);
        t_flags(1);
        t_sequence();
        t_mid_reset();
        final_report();
    end
endmodule // buck_channel_regs_tb_top
